// file: rtl/panel_status.sv
// Operator panel status indicator controller with Avalon-MM registers.
// Assumes machine state and copy events come from logic on clk_i;
// the new drum switch and the clear key are raw pins.
// Summary of operation
// - Pre-heat lamp steady while in energy saving state.
// - Pre-heat lamp blinks during warm-up and recovery from saving.
// - Pre-heat lamp off once recovered and fuser is ready.
// - Maintenance lamp lights at the set count; copying continues.
// - Toner lamp steady once density falls below threshold.
// - After ten more sheets, toner lamp blinks and feed motor runs.
// - Two minutes of feed without recovery: ready off, copying stops.
// - Drum lamp steady when drum copy count reaches 29,000.
// - Drum lamp blinks after 1,000 more copies; copying continues.
// - Clear key held 5 s in user mode shows drum life, 2+3 digits.
// - New drum switch actuation means a new drum is installed.
`timescale 1ns/1ps
module panel_status
  import panel_pkg::*;
#(
  parameter int unsigned TICK_CYC = HALF_CYC
) (
  input wire logic clk_i,                // Clock, 250 MHz
  input wire logic rstn_i,               // Async reset, active low
  input wire logic [4:0] avs_address_i,  // Byte address
  input wire logic avs_read_i,           // Read request
  input wire logic avs_write_i,          // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o,    // Read data
  output logic avs_waitrequest_o,        // Wait request
  input wire logic eco_i,                // Energy saving active
  input wire logic fuse_ready_i,         // Fuser at ready temperature
  input wire logic copying_i,            // Copy in progress
  input wire logic copy_done_i,          // One sheet copied, pulse
  input wire logic [7:0] toner_density_sense_i, // Toner density
  input wire logic new_drum_switch_i,    // Drum reset switch pin
  input wire logic clear_key_i,          // Clear key pin
  input wire logic user_mode_i,          // User service mode
  output lamps_t lamps_o,                // Panel lamps
  output logic toner_feed_motor_o,       // Toner supply drive
  output logic copy_stop_o,              // Inhibit copying
  output disp_t disp_o,                  // Drum life display
  output logic irq_o                     // Interrupt, level
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] thr;
    logic [15:0] maint_set;
    logic [15:0] maint_cnt;
    logic maint_on;
    evt_t sts;
    evt_t mask;
    toner_t tn;
    logic [3:0] sheets;
    logic [7:0] tn_tmr;
    logic [4:0] drum_hi;
    logic [9:0] drum_lo;
    logic drum_warn;
    logic drum_blink;
    logic blink;
    logic [7:0] hold_tmr;
    logic drum_sw_q;
    lamps_t lamps;
    logic feed;
    logic stop;
    disp_t disp;
    logic irq;
  } top_st_t;

  top_st_t st_ff;
  top_st_t nxt_st;
  logic tick;
  logic drum_sw;
  logic clr_key;
  logic req;
  logic low;
  logic new_drum;
  logic drum_empty;
  evt_t evt;
  evt_t clr;

  // ****************************************************************
  // Pins and timebase
  // ****************************************************************
  pin_sync u_drum_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(new_drum_switch_i),
    .level_o(drum_sw)
  );

  pin_sync u_key_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(clear_key_i),
    .level_o(clr_key)
  );

  tick_gen #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_o(tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    evt = '0;
    clr = '0;
    req = avs_read_i | avs_write_i;
    low = toner_density_sense_i < st_ff.thr;
    new_drum = drum_sw & ~st_ff.drum_sw_q;
    drum_empty = (st_ff.drum_hi == 5'h0) && (st_ff.drum_lo == 10'h0);
    nxt_st.drum_sw_q = drum_sw;
    if (tick) begin
      nxt_st.blink = ~st_ff.blink;
    end

    // ****************************************************************
    // Bus: first cycle latches read data, second cycle completes
    // ****************************************************************
    nxt_st.ack = req & ~st_ff.ack;
    if (avs_read_i && !st_ff.ack) begin
      if (avs_address_i == REG_CTRL) begin
        nxt_st.rdata = {24'h0, st_ff.thr};
      end else if (avs_address_i == REG_MAINT_SET) begin
        nxt_st.rdata = {16'h0, st_ff.maint_set};
      end else if (avs_address_i == REG_STATUS) begin
        nxt_st.rdata = {25'h0, st_ff.sts};
      end else if (avs_address_i == REG_MASK) begin
        nxt_st.rdata = {25'h0, st_ff.mask};
      end else if (avs_address_i == REG_STATE) begin
        nxt_st.rdata = {22'h0, st_ff.disp.show, st_ff.stop,
                        st_ff.feed, st_ff.tn, st_ff.lamps};
      end else if (avs_address_i == REG_MAINT_CNT) begin
        nxt_st.rdata = {16'h0, st_ff.maint_cnt};
      end else if (avs_address_i == REG_DRUM_LEFT) begin
        nxt_st.rdata = {16'h0, 1'b0, st_ff.drum_hi, st_ff.drum_lo};
      end else begin
        nxt_st.rdata = '0;
      end
    end
    // ****************************************************************
    // Read of status clears only the bits that were reported
    // ****************************************************************
    if (avs_read_i && st_ff.ack && avs_address_i == REG_STATUS) begin
      clr = evt_t'(st_ff.rdata[STS_W-1:0]);
    end
    if (avs_write_i && st_ff.ack) begin
      if (avs_address_i == REG_CTRL) begin
        nxt_st.thr = avs_writedata_i[7:0];
        if (avs_writedata_i[CTRL_MCLR_BIT]) begin
          nxt_st.maint_cnt = '0;
          nxt_st.maint_on = 1'b0;
        end
      end else if (avs_address_i == REG_MAINT_SET) begin
        nxt_st.maint_set = avs_writedata_i[15:0];
      end else if (avs_address_i == REG_MASK) begin
        nxt_st.mask = evt_t'(avs_writedata_i[STS_W-1:0]);
      end
    end

    // ****************************************************************
    // Maintenance count, lamp only, never stops the machine
    // ****************************************************************
    if (copy_done_i && st_ff.maint_cnt != MAINT_CNT_MAX) begin
      nxt_st.maint_cnt = st_ff.maint_cnt + 16'h1;
    end
    if (nxt_st.maint_cnt >= st_ff.maint_set && st_ff.maint_set != 16'h0
        && !st_ff.maint_on && nxt_st.maint_cnt != 16'h0) begin
      nxt_st.maint_on = 1'b1;
      evt.maint = 1'b1;
    end

    // ****************************************************************
    // Toner supervision
    // ****************************************************************
    case (st_ff.tn)
      TN_OK: begin
        if (low) begin
          nxt_st.tn = TN_LOW;
          nxt_st.sheets = '0;
          evt.toner_low = 1'b1;
        end
      end
      TN_LOW: begin
        if (!low) begin
          nxt_st.tn = TN_OK;
        end else if (copy_done_i) begin
          if (st_ff.sheets == TONER_GRACE - 4'h1) begin
            nxt_st.tn = TN_FEED;
            nxt_st.tn_tmr = '0;
            evt.toner_feed = 1'b1;
          end else begin
            nxt_st.sheets = st_ff.sheets + 4'h1;
          end
        end
      end
      TN_FEED: begin
        if (!low) begin
          nxt_st.tn = TN_OK;
        end else if (tick) begin
          if (st_ff.tn_tmr == TONER_WAIT_TK - 8'h1) begin
            nxt_st.tn = TN_STOP;
            evt.toner_stop = 1'b1;
          end else begin
            nxt_st.tn_tmr = st_ff.tn_tmr + 8'h1;
          end
        end
      end
      TN_STOP: begin
        if (!low) begin
          nxt_st.tn = TN_OK;
        end
      end
      default: begin
        nxt_st.tn = TN_OK;
      end
    endcase

    // ****************************************************************
    // Drum life, counted down as thousands and units
    // ****************************************************************
    if (new_drum) begin
      nxt_st.drum_hi = DRUM_HI_INIT;
      nxt_st.drum_lo = '0;
      nxt_st.drum_warn = 1'b0;
      nxt_st.drum_blink = 1'b0;
      evt.new_drum = 1'b1;
    end else begin
      if (copy_done_i && !drum_empty) begin
        if (st_ff.drum_lo == 10'h0) begin
          nxt_st.drum_lo = DRUM_LO_MAX;
          nxt_st.drum_hi = st_ff.drum_hi - 5'h1;
        end else begin
          nxt_st.drum_lo = st_ff.drum_lo - 10'h1;
        end
      end
      if (!st_ff.drum_warn && (nxt_st.drum_hi < DRUM_WARN_HI
          || (nxt_st.drum_hi == DRUM_WARN_HI
          && nxt_st.drum_lo == 10'h0))) begin
        nxt_st.drum_warn = 1'b1;
        evt.drum_warn = 1'b1;
      end
      if (!st_ff.drum_blink && nxt_st.drum_hi == 5'h0
          && nxt_st.drum_lo == 10'h0) begin
        nxt_st.drum_blink = 1'b1;
        evt.drum_blink = 1'b1;
      end
    end

    // ****************************************************************
    // Drum life display on long clear key press
    // ****************************************************************
    if (!user_mode_i) begin
      nxt_st.disp.show = 1'b0;
      nxt_st.hold_tmr = '0;
    end else if (!clr_key) begin
      nxt_st.hold_tmr = '0;
    end else if (tick && st_ff.hold_tmr != CLEAR_HOLD_TK) begin
      nxt_st.hold_tmr = st_ff.hold_tmr + 8'h1;
    end
    if (user_mode_i && st_ff.hold_tmr == CLEAR_HOLD_TK) begin
      nxt_st.disp.show = 1'b1;
    end
    nxt_st.disp.hi = nxt_st.disp.show ? nxt_st.drum_hi : 5'h0;
    nxt_st.disp.lo = nxt_st.disp.show ? nxt_st.drum_lo : 10'h0;

    // ****************************************************************
    // Lamps and drives
    // ****************************************************************
    if (eco_i) begin
      nxt_st.lamps.preheat = 1'b1;
    end else if (!fuse_ready_i) begin
      nxt_st.lamps.preheat = st_ff.blink;
    end else begin
      nxt_st.lamps.preheat = 1'b0;
    end
    nxt_st.stop = nxt_st.tn == TN_STOP;
    nxt_st.feed = (nxt_st.tn == TN_FEED) || nxt_st.stop;
    nxt_st.lamps.ready = fuse_ready_i & ~eco_i & ~copying_i
                         & ~nxt_st.stop;
    nxt_st.lamps.maint = nxt_st.maint_on;
    if (nxt_st.tn == TN_OK) begin
      nxt_st.lamps.toner = 1'b0;
    end else if (nxt_st.tn == TN_LOW) begin
      nxt_st.lamps.toner = 1'b1;
    end else begin
      nxt_st.lamps.toner = st_ff.blink;
    end
    if (nxt_st.drum_blink) begin
      nxt_st.lamps.drum = st_ff.blink;
    end else begin
      nxt_st.lamps.drum = nxt_st.drum_warn;
    end

    // ****************************************************************
    // Sticky status, a new event wins over the read clear
    // ****************************************************************
    nxt_st.sts = (st_ff.sts & ~clr) | evt;
    nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.thr <= THR_RST;
      st_ff.maint_set <= MAINT_SET_RST;
      st_ff.drum_hi <= DRUM_HI_INIT;
      st_ff.tn <= TN_OK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = req & ~st_ff.ack;
  assign lamps_o = st_ff.lamps;
  assign toner_feed_motor_o = st_ff.feed;
  assign copy_stop_o = st_ff.stop;
  assign disp_o = st_ff.disp;
  assign irq_o = st_ff.irq;

endmodule

// file: rtl/panel_pkg.sv
// Constants, register map and shared types for the panel indicator block.
// Assumes a 250 MHz machine controller clock.
package panel_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int TICKS_PER_S = 1000 / BLINK_HALF_MS;
  localparam int TONER_WAIT_S = 120;
  localparam int CLEAR_HOLD_S = 5;
  localparam logic [7:0] TONER_WAIT_TK = 8'(TONER_WAIT_S * TICKS_PER_S);
  localparam logic [7:0] CLEAR_HOLD_TK = 8'(CLEAR_HOLD_S * TICKS_PER_S);

  // ****************************************************************
  // Copy counts
  // ****************************************************************
  localparam logic [3:0] TONER_GRACE = 4'hA;
  localparam int DRUM_WARN = 29_000;
  localparam int DRUM_EXTRA = 1_000;
  localparam int DRUM_LIFE = DRUM_WARN + DRUM_EXTRA;
  localparam int DRUM_UNIT = 1_000;
  localparam logic [4:0] DRUM_HI_INIT = 5'(DRUM_LIFE / DRUM_UNIT);
  localparam logic [4:0] DRUM_WARN_HI = 5'(DRUM_EXTRA / DRUM_UNIT);
  localparam logic [9:0] DRUM_LO_MAX = 10'(DRUM_UNIT - 1);
  localparam logic [15:0] MAINT_CNT_MAX = 16'hFFFF;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_MAINT_SET = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0C;
  localparam logic [4:0] REG_STATE = 5'h10;
  localparam logic [4:0] REG_MAINT_CNT = 5'h14;
  localparam logic [4:0] REG_DRUM_LEFT = 5'h18;
  localparam int CTRL_MCLR_BIT = 8;
  localparam logic [7:0] THR_RST = 8'h40;
  localparam logic [15:0] MAINT_SET_RST = 16'h2710;
  localparam int STS_W = 7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {TN_OK, TN_LOW, TN_FEED, TN_STOP} toner_t;

  typedef struct packed {
    logic new_drum;
    logic drum_blink;
    logic drum_warn;
    logic toner_stop;
    logic toner_feed;
    logic toner_low;
    logic maint;
  } evt_t;

  typedef struct packed {
    logic preheat;
    logic ready;
    logic maint;
    logic toner;
    logic drum;
  } lamps_t;

  typedef struct packed {
    logic show;
    logic [4:0] hi;
    logic [9:0] lo;
  } disp_t;

endpackage

// file: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin level; output is a clean level on clk_i.
`timescale 1ns/1ps
module pin_sync
  import panel_pkg::*;
(
  input wire logic clk_i,  // Clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic pin_i,  // Raw pin
  output logic level_o     // Filtered level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl = st_ff.s3;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.lvl;

endmodule

// file: rtl/tick_gen.sv
// Periodic one-cycle tick generator.
// Assumes PERIOD of at least one cycle.
`timescale 1ns/1ps
module tick_gen
  import panel_pkg::*;
#(
  parameter int unsigned PERIOD = HALF_CYC
) (
  input wire logic clk_i,  // Clock
  input wire logic rstn_i, // Async reset, active low
  output logic tick_o      // One-cycle pulse
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_st_t;

  tick_st_t st_ff;
  tick_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= 32'(PERIOD - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

// file: bench/machine_model.sv
// Copy engine and panel keys beside the indicator block.
// Assumes the caller enters each task just after a rising edge.
`timescale 1ns/1ps
module machine_model (
  input wire logic clk_i, // Clock
  output logic copying_o, // Copy run level
  output logic done_o,    // One pulse a sheet
  output logic drum_o,    // New drum switch pin
  output logic key_o      // Clear key pin
);
  initial begin
    copying_o = 1'b0;
    done_o = 1'b0;
    drum_o = 1'b0;
    key_o = 1'b0;
  end

  // Sheet pulse every other cycle while the run lasts
  task automatic copies(input int n);
    copying_o <= n > 0;
    repeat (2 * n) begin
      @(posedge clk_i);
      done_o <= ~done_o;
    end
    @(posedge clk_i);
    copying_o <= 1'b0;
  endtask

  // Switch pressed and released, each held for the pin filter
  task automatic swap;
    repeat (2) begin
      drum_o <= ~drum_o;
      repeat (8) @(posedge clk_i);
    end
  endtask

  // Clear key pin level
  task automatic key(input logic v);
    key_o <= v;
  endtask
endmodule

// file: bench/panel_status_assertions.sv
// Port checker for the panel indicator block.
// Assumes the bus master holds a request until waitrequest is low.
`timescale 1ns/1ps
module panel_checker
  import panel_pkg::*;
#(
  parameter int unsigned TICK_CYC = HALF_CYC
) (
  input wire logic clk_i,             // Clock
  input wire logic rstn_i,            // Reset, active low
  input wire logic avs_read_i,        // Read request
  input wire logic avs_write_i,       // Write request
  input wire logic avs_waitrequest_o, // Wait request
  input wire logic eco_i,             // Energy saving
  input wire logic fuse_ready_i,      // Fuser ready
  input wire logic clear_key_i,       // Clear key pin
  input wire logic user_mode_i,       // User service mode
  input wire lamps_t lamps_o,         // Lamps
  input wire logic toner_feed_motor_o, // Toner feed
  input wire logic copy_stop_o,       // Copy inhibit
  input wire disp_t disp_o            // Drum life display
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  wait_first_a: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o) else $error("no wait state");
  wait_one_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("long wait");
  wait_idle_a: assert property (!(avs_read_i || avs_write_i)
    |-> !avs_waitrequest_o) else $error("idle wait");
  eco_lamp_a: assert property (eco_i ##1 eco_i
    |-> lamps_o.preheat && !lamps_o.ready) else $error("eco lamps");
  heat_off_a: assert property (fuse_ready_i && !eco_i
    |=> !lamps_o.preheat) else $error("preheat on");
  stop_ready_a: assert property (copy_stop_o
    |-> !lamps_o.ready) else $error("ready in stop");
  stop_cause_a: assert property ($rose(copy_stop_o)
    |-> $past(toner_feed_motor_o)) else $error("stop no feed");
  feed_keep_a: assert property (copy_stop_o
    |-> toner_feed_motor_o) else $error("feed off");
  disp_idle_a: assert property (!disp_o.show
    |-> disp_o.hi == 5'h00 && disp_o.lo == 10'h000) else $error("disp");
  disp_range_a: assert property (disp_o.lo <= DRUM_LO_MAX
    && disp_o.hi <= DRUM_HI_INIT) else $error("disp range");
  disp_rise_a: assert property ($rose(disp_o.show)
    |-> $past(user_mode_i) && $past(clear_key_i, 8)) else $error("disp rise");
endmodule

bind panel_status panel_checker #(.TICK_CYC(TICK_CYC)) chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .eco_i(eco_i), .fuse_ready_i(fuse_ready_i), .clear_key_i(clear_key_i),
  .user_mode_i(user_mode_i), .lamps_o(lamps_o),
  .toner_feed_motor_o(toner_feed_motor_o), .copy_stop_o(copy_stop_o),
  .disp_o(disp_o)
);

// file: bench/panel_status_tb_top.sv
// Self-checking bench for the panel indicator block.
// Assumes a short blink tick; drum counts run at full length.
`timescale 1ns/1ps
module panel_status_tb_top;
  import panel_pkg::*;
  localparam int TK = 20;
  localparam int PH = 4, RD = 3, MT = 2, TN = 1, DR = 0;
  localparam logic [1:0] OFF = 2'b01, ON = 2'b10, BL = 2'b11;
  logic clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic eco_i, fuse_ready_i, copying_i, copy_done_i, irq_o;
  logic new_drum_switch_i, clear_key_i, user_mode_i;
  logic toner_feed_motor_o, copy_stop_o;
  logic [7:0] toner_density_sense_i;
  lamps_t lamps_o;
  disp_t disp_o;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  panel_status #(.TICK_CYC(TK)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .eco_i(eco_i), .fuse_ready_i(fuse_ready_i), .copying_i(copying_i),
    .copy_done_i(copy_done_i), .toner_density_sense_i(toner_density_sense_i),
    .new_drum_switch_i(new_drum_switch_i), .clear_key_i(clear_key_i),
    .user_mode_i(user_mode_i), .lamps_o(lamps_o),
    .toner_feed_motor_o(toner_feed_motor_o), .copy_stop_o(copy_stop_o),
    .disp_o(disp_o), .irq_o(irq_o));
  machine_model m (.clk_i(clk_i), .copying_o(copying_i),
    .done_o(copy_done_i), .drum_o(new_drum_switch_i), .key_o(clear_key_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    // Answer judged mid-cycle, taken at the following rising edge
    do begin
      @(negedge clk_i);
      n++;
      ok = avs_waitrequest_o === 1'b0;
      rd = avs_readdata_o;
      @(posedge clk_i);
    end while (!ok && n < 50);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, ok}, 32'h1);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Off, steady or blinking over four ticks
  task automatic mode(input int i, input logic [1:0] exp);
    logic [1:0] s;
    s = 2'b00;
    repeat (3) @(posedge clk_i);
    repeat (4 * TK) begin
      @(posedge clk_i);
      s = s | {lamps_o[i] === 1'b1, lamps_o[i] === 1'b0};
    end
    chk({30'h0, s}, {30'h0, exp});
  endtask

  task automatic wait_for(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, s}, 32'h1);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_regs;
    rdchk(REG_CTRL, 32'h40);
    rdchk(REG_MAINT_SET, 32'h2710);
    rdchk(REG_MASK, 32'h0);
    rdchk(REG_DRUM_LEFT, 32'h7800);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    rdchk(5'h1C, 32'h0);
  endtask

  task automatic t_heat;
    mode(PH, BL);
    eco_i <= 1'b1;
    mode(PH, ON);
    eco_i <= 1'b0;
    mode(PH, BL);
    fuse_ready_i <= 1'b1;
    mode(PH, OFF);
    mode(RD, ON);
  endtask

  task automatic t_maint;
    bus(1'b1, REG_MASK, 32'h1);
    rdchk(REG_MASK, 32'h1);
    bus(1'b1, REG_MAINT_SET, 32'h3);
    m.copies(2);
    mode(MT, OFF);
    m.copies(1);
    mode(MT, ON);
    chk({31'h0, copy_stop_o}, 32'h0);
    rdchk(REG_MAINT_CNT, 32'h3);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(REG_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, REG_MASK, 32'h0);
    bus(1'b1, REG_CTRL, 32'h140);
    mode(MT, OFF);
    bus(1'b1, REG_MAINT_SET, 32'h0);
  endtask

  task automatic t_toner;
    toner_density_sense_i <= 8'h30;
    mode(TN, ON);
    m.copies(9);
    chk({31'h0, toner_feed_motor_o}, 32'h0);
    m.copies(1);
    wait_for(toner_feed_motor_o, 20);
    mode(TN, BL);
    repeat (230 * TK) @(posedge clk_i);
    chk({31'h0, copy_stop_o}, 32'h0);
    wait_for(copy_stop_o, 20 * TK);
    mode(RD, OFF);
    mode(TN, BL);
    toner_density_sense_i <= 8'h80;
    mode(TN, OFF);
    chk({30'h0, toner_feed_motor_o, copy_stop_o}, 32'h0);
  endtask

  task automatic t_disp;
    int n;
    n = 0;
    user_mode_i <= 1'b1;
    m.key(1'b1);
    while (disp_o.show !== 1'b1 && n < 16 * TK) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n > 9 * TK}, 32'h1);
    chk({16'h0, disp_o}, 32'h0000F7DB);
    rdchk(REG_STATE, 32'h208);
    m.key(1'b0);
    user_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({31'h0, disp_o.show}, 32'h0);
  endtask

  task automatic t_drum;
    m.copies(28986);
    mode(DR, OFF);
    m.copies(1);
    mode(DR, ON);
    rdchk(REG_DRUM_LEFT, 32'h400);
    m.copies(999);
    mode(DR, ON);
    m.copies(1);
    mode(DR, BL);
    chk({30'h0, copy_stop_o, irq_o}, 32'h0);
    m.swap;
    mode(DR, OFF);
    rdchk(REG_DRUM_LEFT, 32'h7800);
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial begin
    rstn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    eco_i = 1'b0;
    fuse_ready_i = 1'b0;
    user_mode_i = 1'b0;
    toner_density_sense_i = 8'h80;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_heat;
    t_maint;
    t_toner;
    t_disp;
    t_drum;
    end_of_test;
  end
endmodule
